// ---- common/asi_pkg.sv ----
// Package: register map, field layout, phases and state of the serial block
package asi_pkg;

  // Bus widths
  localparam int AW = 18;
  localparam int DW = 32;

  // Register indices; the byte address is four times the index
  localparam logic [15:0] IDX_PRIO  = 16'hff20;
  localparam logic [15:0] IDX_IRQEN = 16'hff23;
  localparam logic [15:0] IDX_CAUSE = 16'hff25;
  localparam logic [15:0] IDX_MODE  = 16'hff48;
  localparam logic [15:0] IDX_CTRL  = 16'hff49;
  localparam logic [15:0] IDX_DATA  = 16'hff4a;

  // Mode register fields
  localparam int PARITY_ON      = 6;
  localparam int PARITY_ODD_SEL = 5;
  localparam int CLK_SRC_LO     = 3;  // clk_src_hi at 4
  localparam int OP_MODE_LO     = 1;  // op_mode_hi at 2
  localparam int SERIAL_PINS_ON = 0;
  localparam int RSV_BIT        = 7;

  // Control and status fields; frame, parity, overrun at 6..4
  localparam int OVERRUN_FLAG = 4;
  localparam int C_RX_GO      = 3;
  localparam int C_RX_ON      = 2;
  localparam int C_TX_GO      = 1;
  localparam int C_TX_ON      = 0;

  // Priority and interrupt fields
  localparam int SERIAL_LEVEL_LO = 4;
  localparam int ERR_IRQ_CAUSE   = 2;
  localparam int Q_REC           = 1;
  localparam int Q_TRA           = 0;

  // Codes and counts
  localparam logic [1:0] CLK_TIMER  = 2'h3;
  localparam logic [1:0] CLK_DIV4   = 2'h2;
  localparam logic [1:0] CLK_DIV8   = 2'h1;
  localparam logic [1:0] CLK_DIV16  = 2'h0;
  localparam logic [3:0] DIV4_LAST  = 4'h3;
  localparam logic [3:0] DIV8_LAST  = 4'h7;
  localparam logic [3:0] DIV16_LAST = 4'hf;
  localparam logic [1:0] OP_ASYNC8  = 2'h3;
  localparam logic [1:0] OP_ASYNC7  = 2'h2;
  localparam logic [3:0] OVS_LAST   = 4'hf;
  localparam logic [3:0] OVS_MID    = 4'h7;
  localparam logic [2:0] BITS8_LAST = 3'h7;
  localparam logic [2:0] BITS7_LAST = 3'h6;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] PINS_OE_SER = 2'h2;
  localparam logic [7:0] REG_RST    = 8'h00;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_HUNT  = 3'b001,
    PH_START = 3'b010,
    PH_DATA  = 3'b011,
    PH_PAR   = 3'b100,
    PH_STOP  = 3'b101
  } asi_phase_t;

  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } asi_pins_t;

  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  prio;
    logic [7:0]  irq_en;
    logic [2:0]  cause;
    logic [2:0]  err;
    logic        rx_en;
    logic        tx_en;
    logic [7:0]  tx_buf;
    logic [7:0]  rx_buf;
    logic        rx_full;
    logic [3:0]  div;
    asi_phase_t  rx_ph;
    logic [3:0]  rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_pbit;
    asi_phase_t  tx_ph;
    logic [3:0]  tx_cnt;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_sh;
    logic        tx_pbit;
    logic        txd;
    logic        aw_ok;
    logic [AW-1:0] aw_addr;
    logic        w_ok;
    logic [7:0]  w_data;
    logic        w_lane;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
  } asi_state_t;

  localparam asi_state_t STATE_RST = '{rx_ph: PH_IDLE, tx_ph: PH_IDLE,
                                       txd: 1'b1, default: '0};

  function automatic logic [AW-1:0] byte_addr(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction : byte_addr

endpackage : asi_pkg

// ---- hdl/asi_serial.sv ----
// Async serial interface with AXI4-Lite register slave
//
// Local design decision: the AXI4-Lite slave port.
module asi_serial (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [asi_pkg::AW-1:0] awaddr,
  input  wire logic                  awvalid,
  output wire logic                  awready,
  input  wire logic [asi_pkg::DW-1:0] wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output wire logic                  wready,
  output wire logic [1:0]            bresp,
  output wire logic                  bvalid,
  input  wire logic                  bready,
  input  wire logic [asi_pkg::AW-1:0] araddr,
  input  wire logic                  arvalid,
  output wire logic                  arready,
  output wire logic [asi_pkg::DW-1:0] rdata,
  output wire logic [1:0]            rresp,
  output wire logic                  rvalid,
  input  wire logic                  rready,
  input  wire logic                  timer1_tick,
  input  wire logic [1:0]            port_dout,
  input  wire logic [1:0]            port_dir,
  input  wire logic [1:0]            pin_in,
  output asi_pkg::asi_pins_t         pins,
  output wire logic                  irq,
  output wire logic [1:0]            irq_level
);
  import asi_pkg::*;

  asi_state_t s_reg;
  asi_state_t s_next;
  logic [3:0] div_last;
  logic       tick;
  logic       async_md;
  logic       seven;
  logic       par_on;
  logic [2:0] last_bit;
  logic       serial_in_pin;
  logic       wr_go;
  logic       rd_go;
  logic [7:0] wd;
  logic       wr_mode;
  logic       wr_ctrl;
  logic       wr_data;
  logic       wr_prio;
  logic       wr_ien;
  logic       wr_cause;
  logic       rx_trg;
  logic       tx_trg;
  logic       rx_busy;
  logic       tx_busy;
  logic       rx_fin;
  logic       tx_end;
  logic [7:0] rx_val;
  logic [2:0] rx_errs;

  // Address match against one register index
  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [15:0]   idx);
    return a == byte_addr(idx);
  endfunction : hit

  // Any mapped register
  function automatic logic mapped(input logic [AW-1:0] a);
    return hit(a, IDX_PRIO) || hit(a, IDX_IRQEN) || hit(a, IDX_CAUSE) ||
           hit(a, IDX_MODE) || hit(a, IDX_CTRL) || hit(a, IDX_DATA);
  endfunction : mapped

  // Parity bit over 7 or 8 data bits
  function automatic logic par_of(input logic [7:0] d,
                                  input logic       sev,
                                  input logic       odd);
    return (^(sev ? {1'b0, d[6:0]} : d)) ^ odd;
  endfunction : par_of

  // Mode decode and bit clock source
  assign async_md = s_reg.mode[OP_MODE_LO+1];
  assign seven    = s_reg.mode[OP_MODE_LO+:2] == OP_ASYNC7;
  assign par_on   = s_reg.mode[PARITY_ON] && async_md;
  assign last_bit = seven ? BITS7_LAST : BITS8_LAST;
  assign div_last = (s_reg.mode[CLK_SRC_LO+:2] == CLK_DIV4) ? DIV4_LAST :
                    (s_reg.mode[CLK_SRC_LO+:2] == CLK_DIV8) ? DIV8_LAST :
                    DIV16_LAST;
  assign tick = (s_reg.mode[CLK_SRC_LO+:2] == CLK_TIMER) ? timer1_tick :
                (s_reg.div == div_last);

  // Line input, idle high when pins are not claimed
  assign serial_in_pin = s_reg.mode[SERIAL_PINS_ON] ? pin_in[0] : 1'b1;

  // Bus handshakes and register write strobes
  assign awready  = !s_reg.aw_ok;
  assign wready   = !s_reg.w_ok;
  assign arready  = !s_reg.rvalid;
  assign bvalid   = s_reg.bvalid;
  assign bresp    = s_reg.bresp;
  assign rvalid   = s_reg.rvalid;
  assign rresp    = s_reg.rresp;
  assign rdata    = {24'h0, s_reg.rdata};
  assign wr_go    = s_reg.aw_ok && s_reg.w_ok && !s_reg.bvalid;
  assign rd_go    = arvalid && !s_reg.rvalid;
  assign wd       = s_reg.w_data;
  assign wr_mode  = wr_go && s_reg.w_lane && hit(s_reg.aw_addr, IDX_MODE);
  assign wr_ctrl  = wr_go && s_reg.w_lane && hit(s_reg.aw_addr, IDX_CTRL);
  assign wr_data  = wr_go && s_reg.w_lane && hit(s_reg.aw_addr, IDX_DATA);
  assign wr_prio  = wr_go && s_reg.w_lane && hit(s_reg.aw_addr, IDX_PRIO);
  assign wr_ien   = wr_go && s_reg.w_lane && hit(s_reg.aw_addr, IDX_IRQEN);
  assign wr_cause = wr_go && s_reg.w_lane && hit(s_reg.aw_addr, IDX_CAUSE);

  // Start requests need the direction enabled and an async mode
  assign rx_trg = wr_ctrl && wd[C_RX_GO] && s_reg.rx_en && async_md;
  assign tx_trg = wr_ctrl && wd[C_TX_GO] && s_reg.tx_en && async_md;
  assign rx_busy = s_reg.rx_ph != PH_IDLE;
  assign tx_busy = s_reg.tx_ph != PH_IDLE;
  assign rx_fin  = s_reg.rx_ph == PH_STOP && tick && s_reg.rx_cnt == OVS_LAST;
  assign tx_end  = tick && s_reg.tx_cnt == OVS_LAST;

  // Next state of the whole block
  always_comb begin
    s_next  = s_reg;
    rx_val  = seven ? {1'b0, s_reg.rx_sh[7:1]} : s_reg.rx_sh;
    rx_errs = {!serial_in_pin,
               par_on && (s_reg.rx_pbit !=
                          par_of(rx_val, seven, s_reg.mode[PARITY_ODD_SEL])),
               s_reg.rx_full};
    s_next.div = (s_reg.div == div_last) ? '0 : s_reg.div + 4'h1;

    // Write address and data taken in either order
    if (awvalid && !s_reg.aw_ok) begin
      s_next.aw_ok   = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && !s_reg.w_ok) begin
      s_next.w_ok   = 1'b1;
      s_next.w_data = wdata[7:0];
      s_next.w_lane = wstrb[0];
    end
    if (wr_go) begin
      s_next.aw_ok  = 1'b0;
      s_next.w_ok   = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = mapped(s_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end

    // Register writes; clears come first so hardware sets win
    if (wr_mode) begin
      s_next.mode = {1'b0, wd[RSV_BIT-1:0]};
    end
    if (wr_prio) begin
      s_next.prio = wd;
    end
    if (wr_ien) begin
      s_next.irq_en = wd;
    end
    if (wr_data) begin
      s_next.tx_buf = wd;
    end
    if (wr_ctrl) begin
      s_next.rx_en = wd[C_RX_ON];
      s_next.tx_en = wd[C_TX_ON];
      s_next.err   = s_reg.err & ~wd[OVERRUN_FLAG+:3];
    end
    if (wr_cause) begin
      s_next.cause = s_reg.cause & ~wd[Q_TRA+:3];
    end

    // Register reads
    if (rd_go) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      s_next.rdata  = REG_RST;
      if (hit(araddr, IDX_MODE)) begin
        s_next.rdata = s_reg.mode;
      end
      if (hit(araddr, IDX_CTRL)) begin
        s_next.rdata = {1'b0, s_reg.err, rx_busy, s_reg.rx_en,
                        tx_busy, s_reg.tx_en};
      end
      if (hit(araddr, IDX_DATA)) begin
        s_next.rdata   = s_reg.rx_buf;
        s_next.rx_full = 1'b0;
      end
      if (hit(araddr, IDX_PRIO)) begin
        s_next.rdata = s_reg.prio;
      end
      if (hit(araddr, IDX_IRQEN)) begin
        s_next.rdata = s_reg.irq_en;
      end
      if (hit(araddr, IDX_CAUSE)) begin
        s_next.rdata = {5'h0, s_reg.cause};
      end
    end else if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end

    // Receiver: hunt start edge, sample mid-bit, LSB first
    if (tick && rx_busy) begin
      s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
    end
    unique case (s_reg.rx_ph)
      PH_IDLE: begin
        if (rx_trg) begin
          s_next.rx_ph = PH_HUNT;
        end
      end
      PH_HUNT: begin
        if (tick && !serial_in_pin) begin
          s_next.rx_ph  = PH_START;
          s_next.rx_cnt = '0;
        end
      end
      PH_START: begin
        if (tick && s_reg.rx_cnt == OVS_MID) begin
          s_next.rx_cnt = '0;
          s_next.rx_bit = '0;
          s_next.rx_ph  = serial_in_pin ? PH_HUNT : PH_DATA;
        end
      end
      PH_DATA: begin
        if (tick && s_reg.rx_cnt == OVS_LAST) begin
          s_next.rx_sh  = {serial_in_pin, s_reg.rx_sh[7:1]};
          s_next.rx_bit = s_reg.rx_bit + 3'h1;
          if (s_reg.rx_bit == last_bit) begin
            s_next.rx_ph = par_on ? PH_PAR : PH_STOP;
          end
        end
      end
      PH_PAR: begin
        if (tick && s_reg.rx_cnt == OVS_LAST) begin
          s_next.rx_pbit = serial_in_pin;
          s_next.rx_ph   = PH_STOP;
        end
      end
      PH_STOP: begin
        if (rx_fin) begin
          s_next.rx_ph        = PH_IDLE;
          s_next.rx_buf       = rx_val;
          s_next.rx_full      = 1'b1;
          s_next.err          = s_next.err | rx_errs;
          s_next.cause[Q_REC] = 1'b1;
          if (|rx_errs) begin
            s_next.cause[ERR_IRQ_CAUSE] = 1'b1;
          end
        end
      end
      default: begin
        s_next.rx_ph = PH_IDLE;
      end
    endcase
    if (!s_reg.rx_en) begin
      s_next.rx_ph = PH_IDLE;
    end

    // Transmitter: 16 ticks per bit, line idles high
    if (tick && tx_busy) begin
      s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
    end
    unique case (s_reg.tx_ph)
      PH_IDLE: begin
        if (tx_trg) begin
          s_next.tx_ph   = PH_START;
          s_next.tx_cnt  = '0;
          s_next.tx_sh   = s_reg.tx_buf;
          s_next.tx_pbit = par_of(s_reg.tx_buf, seven,
                                  s_reg.mode[PARITY_ODD_SEL]);
          s_next.txd     = 1'b0;
        end
      end
      PH_START: begin
        if (tx_end) begin
          s_next.tx_ph  = PH_DATA;
          s_next.tx_bit = '0;
          s_next.txd    = s_reg.tx_sh[0];
        end
      end
      PH_DATA: begin
        if (tx_end && s_reg.tx_bit == last_bit) begin
          s_next.tx_ph = par_on ? PH_PAR : PH_STOP;
          s_next.txd   = par_on ? s_reg.tx_pbit : 1'b1;
        end else if (tx_end) begin
          s_next.tx_bit = s_reg.tx_bit + 3'h1;
          s_next.tx_sh  = {1'b0, s_reg.tx_sh[7:1]};
          s_next.txd    = s_reg.tx_sh[1];
        end
      end
      PH_PAR: begin
        if (tx_end) begin
          s_next.tx_ph = PH_STOP;
          s_next.txd   = 1'b1;
        end
      end
      PH_STOP: begin
        if (tx_end) begin
          s_next.tx_ph        = PH_IDLE;
          s_next.cause[Q_TRA] = 1'b1;
        end
      end
      default: begin
        s_next.tx_ph = PH_IDLE;
        s_next.txd   = 1'b1;
      end
    endcase
    if (!s_reg.tx_en) begin
      s_next.tx_ph = PH_IDLE;
      s_next.txd   = 1'b1;
    end
  end

  // State register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Pin takeover, interrupt request and level
  assign pins.oe  = s_reg.mode[SERIAL_PINS_ON] ? PINS_OE_SER : port_dir;
  assign pins.out = s_reg.mode[SERIAL_PINS_ON] ? {s_reg.txd, 1'b0} :
                    port_dout;
  assign irq = |(s_reg.cause & s_reg.irq_en[Q_TRA+:3]);
  assign irq_level = s_reg.prio[SERIAL_LEVEL_LO+:2];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_tx_start;
    (s_reg.tx_ph == PH_IDLE) ##1 (s_reg.tx_ph == PH_START);
  endsequence

  sequence s_div4_run;
    (tick && s_reg.mode[CLK_SRC_LO+:2] == CLK_DIV4)
      ##1 (s_reg.mode[CLK_SRC_LO+:2] == CLK_DIV4 && !tick)[*3];
  endsequence

  a_par_bit: assert property (s_reg.tx_ph == PH_PAR |->
    par_on && s_reg.txd == s_reg.tx_pbit)
    else $error("parity bit wrong or parity off");
  a_div_four: assert property (s_div4_run ##1
    (s_reg.mode[CLK_SRC_LO+:2] == CLK_DIV4) |-> tick)
    else $error("divide by four tick missing");
  a_seven_bits: assert property (s_reg.tx_ph == PH_DATA && tx_end &&
    s_reg.tx_bit == BITS7_LAST |=>
    (s_reg.tx_ph == PH_DATA) == ($past(s_reg.mode[OP_MODE_LO+:2]) ==
    OP_ASYNC8 && $past(s_reg.tx_en)))
    else $error("data bit count wrong for mode");
  a_pin_claim: assert property (s_reg.mode[SERIAL_PINS_ON] |->
    pins.oe == PINS_OE_SER && pins.out[1] == s_reg.txd)
    else $error("serial pins not claimed");
  a_err_clear: assert property (wr_ctrl && wd[OVERRUN_FLAG+2] &&
    !rx_fin |=> !s_reg.err[2])
    else $error("frame error flag not cleared");
  a_trig_start: assert property (rx_trg && !rx_busy |=>
    s_reg.rx_ph == PH_HUNT ##1 s_reg.rx_ph != PH_IDLE || !s_reg.rx_en)
    else $error("receive trigger did not start");
  a_status_rd: assert property (rd_go && hit(araddr, IDX_CTRL) |=>
    s_reg.rdata[C_RX_GO] == $past(rx_busy) &&
    s_reg.rdata[C_TX_GO] == $past(tx_busy))
    else $error("status read wrong");
  a_dir_reset: assert property (!s_reg.tx_en |=> !tx_busy && s_reg.txd)
    else $error("transmit not held in reset");
  a_data_rd: assert property (rd_go && hit(araddr, IDX_DATA) |=>
    s_reg.rdata == $past(s_reg.rx_buf))
    else $error("data read wrong");
  a_irq_gate: assert property ($rose(s_reg.cause[ERR_IRQ_CAUSE]) |->
    irq == (s_reg.irq_en[ERR_IRQ_CAUSE] || |(s_reg.cause[Q_TRA+:2] &
    s_reg.irq_en[Q_TRA+:2])))
    else $error("error interrupt gating wrong");
  a_cause_set: assert property (rx_fin |=> s_reg.cause[Q_REC])
    else $error("receive cause not set");
  a_tx_frame: assert property (s_tx_start |-> !s_reg.txd ##1
    (!s_reg.txd || s_reg.tx_ph != PH_START))
    else $error("start bit not low");
  a_rsv_zero: assert property (rd_go && (hit(araddr, IDX_MODE) ||
    hit(araddr, IDX_CTRL)) |=> !s_reg.rdata[RSV_BIT])
    else $error("reserved bit not zero");

endmodule : asi_serial

// ---- sim/asi_remote.sv ----
// Remote serial device model: sends and captures framed characters
module asi_remote (
  input  wire logic aclk,
  input  wire logic line_in,
  output logic      line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import asi_pkg::*;

  // Line idles high between frames
  initial line_out = 1'h1;

  // One frame: low start, data low bit first, parity, stop
  task automatic send(input logic [7:0] d, input int nb, input logic pon,
                      input logic odd, input logic bp, input logic bs,
                      input int bc);
    logic q[$];
    q = {1'h0};
    for (int i = 0; i < nb; i++) q.push_back(d[i]);
    if (pon) begin
      q.push_back(^(d & (nb == 7 ? 8'h7f : 8'hff)) ^ odd ^ bp);
    end
    q.push_back(~bs);
    foreach (q[i]) begin
      line_out <= q[i];
      repeat (bc) @(posedge aclk);
    end
    line_out <= 1'h1;
  endtask : send

  // Waits for a start edge, then samples each bit at its middle
  task automatic grab(input int nb, input logic pon, input int bc,
                      output logic [15:0] f);
    f = '1;
    while (line_in !== 1'h0) @(posedge aclk);
    repeat (bc / 2) @(posedge aclk);
    for (int i = 0; i < nb + 2 + pon; i++) begin
      f[i] = line_in;
      repeat (bc) @(posedge aclk);
    end
  endtask : grab
endmodule : asi_remote

// ---- sim/tb_top.sv ----
// Self-checking bench for the async serial block and its register bus
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import asi_pkg::*;

  logic          aclk = 1'h0;
  logic          aresetn = 1'h0;
  logic [AW-1:0] awaddr = '0;
  logic          awvalid = 1'h0;
  logic [DW-1:0] wdata = '0;
  logic [3:0]    wstrb = 4'hf;
  logic          wvalid = 1'h0;
  logic          bready = 1'h1;
  logic [AW-1:0] araddr = '0;
  logic          arvalid = 1'h0;
  logic          rready = 1'h1;
  logic          timer1_tick = 1'h0;
  logic [1:0]    port_dout = 2'h0;
  logic [1:0]    port_dir = 2'h0;
  logic [1:0]    tcnt = 2'h0;
  logic          awready, wready, bvalid, arready, rvalid, irq;
  logic          rx_line, tx_line;
  logic [1:0]    bresp, rresp, irq_level;
  logic [DW-1:0] rdata;
  asi_pins_t     pins;
  int            bad_count = 0;
  int            samples_checked = 0;

  // Far end of the output pin idles high when not driven
  assign tx_line = pins.oe[1] ? pins.out[1] : 1'h1;

  asi_serial dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .timer1_tick,
    .port_dout, .port_dir, .pin_in({tx_line, rx_line}), .pins, .irq,
    .irq_level
  );
  asi_remote remote (.aclk, .line_in(tx_line), .line_out(rx_line));

  // Clock, and a timer tick every third cycle
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
    timer1_tick <= (tcnt == 2'h2);
  end

  task automatic chk(input string nm, input logic [15:0] e, s);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Bus write: address and data offered together, then the response
  task automatic wr(input logic [15:0] i, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'h0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'h0;
      end
    join
    do @(posedge aclk); while (bvalid !== 1'h1);
    chk("bresp", {14'h0, er}, {14'h0, bresp});
  endtask : wr

  task automatic rd(input logic [15:0] i, output logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    araddr <= {i, 2'h0};
    arvalid <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    d = rdata[7:0];
    chk("rresp", {14'h0, er}, {14'h0, rresp});
  endtask : rd

  task automatic rc(input logic [15:0] i, input logic [7:0] e,
                    input string nm);
    logic [7:0] v;
    rd(i, v);
    chk(nm, {8'h0, e}, {8'h0, v});
  endtask : rc

  // Expected line frame, start bit in bit 0, idle ones above
  function automatic logic [15:0] frame(input logic [7:0] d, input int nb,
                                        input logic pon, input logic odd);
    frame = '1;
    frame[0] = 1'h0;
    for (int i = 0; i < nb; i++) frame[i + 1] = d[i];
    if (pon) frame[nb + 1] = ^d[6:0] ^ (nb == 8 && d[7]) ^ odd;
  endfunction : frame

  // Reset values, reserved bits, unmapped place, priority level
  task automatic t_regs();
    logic [7:0] v;
    rc(IDX_PRIO, 8'h00, "prio");
    rc(IDX_IRQEN, 8'h00, "irq_en");
    rc(IDX_CAUSE, 8'h00, "cause");
    rc(IDX_MODE, 8'h00, "mode");
    rc(IDX_CTRL, 8'h00, "ctrl");
    rd(16'h0100, v, RESP_SLVERR);
    chk("unmapped", 16'h0, {8'h0, v});
    wr(16'h0100, 8'hff, RESP_SLVERR);
    wr(IDX_MODE, 8'hff);
    rc(IDX_MODE, 8'h7f, "mode_b7");
    wr(IDX_CTRL, 8'h80);
    rc(IDX_CTRL, 8'h00, "ctrl_b7");
    for (int k = 0; k < 4; k++) begin
      wr(IDX_PRIO, 8'(k * 16));
      chk("level", 16'(k), {14'h0, irq_level});
    end
  endtask : t_regs

  // Pins follow the port when off, serial direction when on
  task automatic t_pins();
    wr(IDX_MODE, 8'h00);
    port_dir <= 2'h1;
    port_dout <= 2'h2;
    @(posedge aclk);
    chk("port_oe", 16'h1, {14'h0, pins.oe});
    chk("port_out", 16'h2, {14'h0, pins.out});
    wr(IDX_MODE, 8'h17);
    chk("ser_oe", 16'h2, {14'h0, pins.oe});
    chk("idle", 16'h1, {15'h0, tx_line});
  endtask : t_pins

  // One character out: frame, status, cause and interrupt
  task automatic t_tx(input logic [7:0] m, input int nb, input logic pon,
                      input logic odd, input int bc, input logic [7:0] d);
    logic [7:0] v;
    logic [15:0] f;
    wr(IDX_MODE, m);
    wr(IDX_CTRL, 8'h01);
    wr(IDX_DATA, d);
    rc(IDX_CTRL, 8'h01, "tx_idle");
    wr(IDX_CTRL, 8'h03);
    rc(IDX_CTRL, 8'h03, "tx_busy");
    remote.grab(nb, pon, bc, f);
    chk("frame", frame(d, nb, pon, odd), f);
    do rd(IDX_CTRL, v); while (v[1] === 1'h1);
    rc(IDX_CAUSE, 8'h01, "cause_tx");
    chk("irq_off", 16'h0, {15'h0, irq});
    wr(IDX_IRQEN, 8'h01);
    chk("irq_on", 16'h1, {15'h0, irq});
    wr(IDX_CAUSE, 8'h00);
    rc(IDX_CAUSE, 8'h01, "w0_keep");
    wr(IDX_CAUSE, 8'h01);
    chk("irq_clr", 16'h0, {15'h0, irq});
    wr(IDX_IRQEN, 8'h00);
  endtask : t_tx

  // Synchronous mode leaves the asynchronous transmitter idle
  task automatic t_sync();
    for (int k = 0; k < 2; k++) begin
      wr(IDX_MODE, 8'(1 + k * 2));
      wr(IDX_CTRL, 8'h01);
      wr(IDX_CTRL, 8'h03);
      rc(IDX_CTRL, 8'h01, "sync_idle");
    end
  endtask : t_sync

  // Transmit disabled mid-frame: line high, no completion
  task automatic t_abort();
    wr(IDX_MODE, 8'h17);
    wr(IDX_CTRL, 8'h01);
    wr(IDX_DATA, 8'h00);
    wr(IDX_CTRL, 8'h03);
    repeat (100) @(posedge aclk);
    wr(IDX_CTRL, 8'h00);
    rc(IDX_CTRL, 8'h00, "tx_stop");
    repeat (200) @(posedge aclk);
    chk("line_hi", 16'h1, {15'h0, tx_line});
    rc(IDX_CAUSE, 8'h00, "no_done");
  endtask : t_abort

  // One character in: data, error flags, causes, error interrupt
  task automatic t_rx(input logic [7:0] d, input logic bp, input logic bs,
                      input logic [2:0] fl, input logic rdd);
    logic [7:0] v;
    wr(IDX_MODE, 8'h57);
    wr(IDX_IRQEN, 8'h04);
    wr(IDX_CTRL, 8'h04);
    wr(IDX_CTRL, 8'h0c);
    rc(IDX_CTRL, 8'h0c, "rx_busy");
    remote.send(d, 8, 1'h1, 1'h0, bp, bs, 64);
    do rd(IDX_CTRL, v); while (v[3] === 1'h1);
    chk("ctrl_flags", {9'h0, fl, 4'h4}, {8'h0, v});
    rc(IDX_CAUSE, {5'h0, |fl, 2'h2}, "cause_rx");
    chk("irq_err", {15'h0, |fl}, {15'h0, irq});
    if (rdd) rc(IDX_DATA, d, "rx_data");
    wr(IDX_CTRL, 8'h74);
    rc(IDX_CTRL, 8'h04, "flag_clr");
    wr(IDX_CAUSE, 8'h07);
  endtask : t_rx

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_pins();
    t_tx(8'h17, 8, 1'h0, 1'h0, 64, 8'ha6);
    t_tx(8'h4f, 8, 1'h1, 1'h0, 128, 8'h3b);
    t_tx(8'h65, 7, 1'h1, 1'h1, 256, 8'hc5);
    t_tx(8'h7f, 8, 1'h1, 1'h1, 48, 8'h5e);
    t_sync();
    t_abort();
    t_rx(8'ha5, 1'h0, 1'h0, 3'h0, 1'h1);
    t_rx(8'h3c, 1'h1, 1'h0, 3'h2, 1'h0);
    t_rx(8'h96, 1'h0, 1'h1, 3'h5, 1'h1);
    conclude();
  end

  // Watchdog, several times the expected run
  initial begin
    #1ms;
    bad_count++;
    conclude();
  end
endmodule : tb_top
